// [design/sre_pkg.sv]
// constants for the second-location start/stop and run enable block
// assumes one 25 MHz control clock and an AXI4-Lite register master
`default_nettype none
package sre_pkg;
	// ----------------------------------------
	// register offsets and bus answers
	// ----------------------------------------
	localparam int        ADDR_W        = 8;
	localparam logic [7:0] OFF_CMD_SEL  = 8'h00;
	localparam logic [7:0] OFF_TRIG     = 8'h04;
	localparam logic [7:0] OFF_IN_A     = 8'h08;
	localparam logic [7:0] OFF_IN_B     = 8'h0C;
	localparam logic [7:0] OFF_IN_C     = 8'h10;
	localparam logic [7:0] OFF_STOP     = 8'h14;
	localparam logic [7:0] OFF_RUN_SEL  = 8'h18;
	localparam logic [7:0] OFF_STATUS   = 8'h1C;
	localparam logic [1:0] RESP_OKAY    = 2'h0;
	localparam logic [1:0] RESP_SLVERR  = 2'h2;
	// ----------------------------------------
	// command location codes
	// ----------------------------------------
	localparam logic [4:0] CMD_NONE     = 5'h00;
	localparam logic [4:0] CMD_START    = 5'h01;
	localparam logic [4:0] CMD_START_DIR = 5'h02;
	localparam logic [4:0] CMD_FWD_REV  = 5'h03;
	localparam logic [4:0] CMD_P_STOP   = 5'h04;
	localparam logic [4:0] CMD_P_STOP_DIR = 5'h05;
	localparam logic [4:0] CMD_P_FR_STOP = 5'h06;
	localparam logic [4:0] CMD_PANEL    = 5'h0B;
	localparam logic [4:0] CMD_FBA      = 5'h0C;
	localparam logic [4:0] CMD_EFB      = 5'h0E;
	// ----------------------------------------
	// source codes, trigger and stop modes
	// ----------------------------------------
	localparam logic [4:0] SRC_OFF      = 5'h00;
	localparam logic [4:0] SRC_ON       = 5'h01;
	localparam int        SRC_DI_POS    = 2;
	localparam int        SRC_FBA_POS   = 30;
	localparam int        SRC_EFB_POS   = 31;
	localparam logic      TRIG_EDGE     = 1'b0;
	localparam logic      TRIG_LEVEL    = 1'b1;
	localparam logic      STOP_COAST    = 1'b0;
	localparam logic      STOP_RAMP     = 1'b1;
	// ----------------------------------------
	// values after reset
	// ----------------------------------------
	localparam logic [4:0] CMD_SEL_RST  = CMD_NONE;
	localparam logic      TRIG_RST      = TRIG_LEVEL;
	localparam logic [4:0] IN_SEL_RST   = SRC_OFF;
	localparam logic      STOP_RST      = STOP_COAST;
	localparam logic [4:0] RUN_SEL_RST  = SRC_ON;
	typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_RAMP} sre_state_type;
endpackage
`default_nettype wire

// [design/sre_src_mux.sv]
// one-of-32 source selector for command and run enable inputs
// assumes the source vector is already in the control clock domain
`default_nettype none
module sre_src_mux
	import sre_pkg::*;
(
	// source vector and code
	input  wire logic [31:0] src_vec,
	input  wire logic [4:0]  sel,
	// selected bit
	output logic             bit_out
);
	assign bit_out = src_vec[sel];
endmodule
`default_nettype wire

// [design/sre_axil_slave.sv]
// axi4-lite slave front end: handshakes, one write and one read
// assumes register decode and read data come combinationally from above
`default_nettype none
module sre_axil_slave
	import sre_pkg::*;
(
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_n,
	// write channels
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	input  wire logic              wvalid,
	output logic                   wready,
	output logic [1:0]             bresp,
	output logic                   bvalid,
	input  wire logic              bready,
	// read channels
	input  wire logic [ADDR_W-1:0] araddr,
	input  wire logic              arvalid,
	output logic                   arready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	output logic                   rvalid,
	input  wire logic              rready,
	// register side
	output logic                   reg_wr,
	output logic [ADDR_W-1:0]      wr_addr,
	output logic [31:0]            wr_data,
	output logic [3:0]             wr_strb,
	input  wire logic              wr_ok,
	output logic [ADDR_W-1:0]      rd_addr,
	input  wire logic [31:0]       rd_data,
	input  wire logic              rd_ok
);
	logic aw_held, w_held;
	logic next_aw_held, next_w_held, next_bvalid, next_rvalid;
	logic [ADDR_W-1:0] next_wr_addr;
	logic [31:0] next_wr_data, next_rdata;
	logic [3:0] next_wr_strb;
	logic [1:0] next_bresp, next_rresp;

	// address and data may arrive in either order; both wait for bvalid
	assign awready = !aw_held && !bvalid;
	assign wready  = !w_held && !bvalid;
	assign arready = !rvalid;
	assign reg_wr  = aw_held && w_held && !bvalid;
	assign rd_addr = araddr;

	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_wr_addr = wr_addr;
		next_wr_data = wr_data;
		next_wr_strb = wr_strb;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (awvalid && awready) begin
			next_aw_held = 1'b1;
			next_wr_addr = awaddr;
		end
		if (wvalid && wready) begin
			next_w_held  = 1'b1;
			next_wr_data = wdata;
			next_wr_strb = wstrb;
		end
		if (reg_wr) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			next_bresp   = wr_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid && bready) begin
			next_bvalid = 1'b0;
		end
		if (arvalid && arready) begin
			next_rvalid = 1'b1;
			next_rdata  = rd_ok ? rd_data : 32'h0000_0000;
			next_rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			next_rvalid = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			wr_addr <= '0;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
			rvalid  <= 1'b0;
			rdata   <= 32'h0000_0000;
			rresp   <= RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held  <= next_w_held;
			wr_addr <= next_wr_addr;
			wr_data <= next_wr_data;
			wr_strb <= next_wr_strb;
			bvalid  <= next_bvalid;
			bresp   <= next_bresp;
			rvalid  <= next_rvalid;
			rdata   <= next_rdata;
			rresp   <= next_rresp;
		end
	end
endmodule
`default_nettype wire

// [design/sre_top.sv]
// start/stop decoding for the second external control location,
// with run enable gating and selectable stop mode
// assumes one MCLK domain; digital inputs arrive debounced from pins,
// panel and fieldbus commands come from logic on MCLK
//
// Decided for this implementation: the address map and the AXI4-Lite register port.
`default_nettype none

// Summary of operation
// - three-input pulse mode ignores trigger type
// - code 14 takes commands from embedded fieldbus
// - second input selectable, defaults to off
// - third input selectable, defaults to off
// - stop-mode setting for enable loss, default coast
// - coast: output stage off at once
// - ramp: follow active deceleration ramp
// - no start while run enable inactive
// - enable loss while running stops by mode
// - logic one on source means enabled
// - enable selector locked while running
// - code 2 selects first digital input
// - code 3 selects second digital input
module sre_top
	import sre_pkg::*;
#(
	parameter int NUM_DI = 6
)(
	// clock and reset
	input  wire logic              MCLK,
	input  wire logic              RST_N,
	// axi4-lite write
	input  wire logic [ADDR_W-1:0] S_AXI_AWADDR,
	input  wire logic              S_AXI_AWVALID,
	output logic                   S_AXI_AWREADY,
	input  wire logic [31:0]       S_AXI_WDATA,
	input  wire logic [3:0]        S_AXI_WSTRB,
	input  wire logic              S_AXI_WVALID,
	output logic                   S_AXI_WREADY,
	output logic [1:0]             S_AXI_BRESP,
	output logic                   S_AXI_BVALID,
	input  wire logic              S_AXI_BREADY,
	// axi4-lite read
	input  wire logic [ADDR_W-1:0] S_AXI_ARADDR,
	input  wire logic              S_AXI_ARVALID,
	output logic                   S_AXI_ARREADY,
	output logic [31:0]            S_AXI_RDATA,
	output logic [1:0]             S_AXI_RRESP,
	output logic                   S_AXI_RVALID,
	input  wire logic              S_AXI_RREADY,
	// digital input pins, debounced
	input  wire logic [NUM_DI-1:0] DIG_IN,
	// panel and fieldbus commands
	input  wire logic              PANEL_START,
	input  wire logic              PANEL_REV,
	input  wire logic              FBA_START,
	input  wire logic              FBA_REV,
	input  wire logic              EFB_START,
	input  wire logic              EFB_REV,
	input  wire logic              FBA_CW_BIT3,
	input  wire logic              EFB_CW_BIT3,
	// ramp generator feedback
	input  wire logic              ZERO_SPEED,
	// drive outputs
	output logic                   POWER_STAGE_ON,
	output logic                   RAMP_STOP,
	output logic                   MOTOR_RUN,
	output logic                   REVERSE
);
	// ----------------------------------------
	// declarations
	// ----------------------------------------
	logic [NUM_DI-1:0] di_meta, di_sync;
	logic [4:0] cmd_sel, next_cmd_sel;
	logic       trig, next_trig;
	logic [4:0] in_sel [0:2];
	logic [4:0] next_in_sel [0:2];
	logic       stop_mode, next_stop_mode;
	logic [4:0] run_sel, next_run_sel;
	logic [4:0] mux_sel [0:3];
	logic [3:0] mux_out;
	logic [31:0] src_vec;
	logic [2:0] in_cur, in_prev, rise;
	logic       run_en;
	logic       start_req, stop_req, rev_req, dir_follow;
	logic       lvl_a, lvl_b;
	logic       refused;
	sre_state_type state, next_state;
	logic       next_power, next_ramp, next_run, next_rev;
	logic       reg_wr, wr_ok, rd_ok, wr_en;
	logic [ADDR_W-1:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	logic       running;

	// ----------------------------------------
	// pin synchroniser
	// ----------------------------------------
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			di_meta <= '0;
			di_sync <= '0;
		end else begin
			di_meta <= DIG_IN;
			di_sync <= di_meta;
		end
	end

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	sre_axil_slave u_bus (
		.clk     (MCLK),
		.rst_n   (RST_N),
		.awaddr  (S_AXI_AWADDR),
		.awvalid (S_AXI_AWVALID),
		.awready (S_AXI_AWREADY),
		.wdata   (S_AXI_WDATA),
		.wstrb   (S_AXI_WSTRB),
		.wvalid  (S_AXI_WVALID),
		.wready  (S_AXI_WREADY),
		.bresp   (S_AXI_BRESP),
		.bvalid  (S_AXI_BVALID),
		.bready  (S_AXI_BREADY),
		.araddr  (S_AXI_ARADDR),
		.arvalid (S_AXI_ARVALID),
		.arready (S_AXI_ARREADY),
		.rdata   (S_AXI_RDATA),
		.rresp   (S_AXI_RRESP),
		.rvalid  (S_AXI_RVALID),
		.rready  (S_AXI_RREADY),
		.reg_wr  (reg_wr),
		.wr_addr (wr_addr),
		.wr_data (wr_data),
		.wr_strb (wr_strb),
		.wr_ok   (wr_ok),
		.rd_addr (rd_addr),
		.rd_data (rd_data),
		.rd_ok   (rd_ok)
	);

	assign running = (state != ST_IDLE);

	// status is read-only; the enable selector refuses writes in motion
	always_comb begin
		if (wr_addr == OFF_CMD_SEL || wr_addr == OFF_TRIG) begin
			wr_ok = 1'b1;
		end else if (wr_addr == OFF_IN_A || wr_addr == OFF_IN_B) begin
			wr_ok = 1'b1;
		end else if (wr_addr == OFF_IN_C || wr_addr == OFF_STOP) begin
			wr_ok = 1'b1;
		end else if (wr_addr == OFF_RUN_SEL) begin
			wr_ok = !running;
		end else begin
			wr_ok = 1'b0;
		end
	end

	// all fields sit in byte lane 0
	assign wr_en = reg_wr && wr_ok && wr_strb[0];

	always_comb begin
		next_cmd_sel   = cmd_sel;
		next_trig      = trig;
		next_in_sel    = in_sel;
		next_stop_mode = stop_mode;
		next_run_sel   = run_sel;
		if (wr_en) begin
			if (wr_addr == OFF_CMD_SEL) begin
				next_cmd_sel = wr_data[4:0];
			end else if (wr_addr == OFF_TRIG) begin
				next_trig = wr_data[0];
			end else if (wr_addr == OFF_IN_A) begin
				next_in_sel[0] = wr_data[4:0];
			end else if (wr_addr == OFF_IN_B) begin
				next_in_sel[1] = wr_data[4:0];
			end else if (wr_addr == OFF_IN_C) begin
				next_in_sel[2] = wr_data[4:0];
			end else if (wr_addr == OFF_STOP) begin
				next_stop_mode = wr_data[0];
			end else if (wr_addr == OFF_RUN_SEL) begin
				next_run_sel = wr_data[4:0];
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			cmd_sel   <= CMD_SEL_RST;
			trig      <= TRIG_RST;
			in_sel    <= '{IN_SEL_RST, IN_SEL_RST, IN_SEL_RST};
			stop_mode <= STOP_RST;
			run_sel   <= RUN_SEL_RST;
		end else begin
			cmd_sel   <= next_cmd_sel;
			trig      <= next_trig;
			in_sel    <= next_in_sel;
			stop_mode <= next_stop_mode;
			run_sel   <= next_run_sel;
		end
	end

	always_comb begin
		rd_ok   = 1'b1;
		rd_data = 32'h0000_0000;
		if (rd_addr == OFF_CMD_SEL) begin
			rd_data[4:0] = cmd_sel;
		end else if (rd_addr == OFF_TRIG) begin
			rd_data[0] = trig;
		end else if (rd_addr == OFF_IN_A) begin
			rd_data[4:0] = in_sel[0];
		end else if (rd_addr == OFF_IN_B) begin
			rd_data[4:0] = in_sel[1];
		end else if (rd_addr == OFF_IN_C) begin
			rd_data[4:0] = in_sel[2];
		end else if (rd_addr == OFF_STOP) begin
			rd_data[0] = stop_mode;
		end else if (rd_addr == OFF_RUN_SEL) begin
			rd_data[4:0] = run_sel;
		end else if (rd_addr == OFF_STATUS) begin
			rd_data[7:0] = {in_cur, refused, run_en,
				REVERSE, RAMP_STOP, POWER_STAGE_ON};
			rd_data[8 +: NUM_DI] = di_sync;
		end else begin
			rd_ok = 1'b0;
		end
	end

	// ----------------------------------------
	// source selection
	// ----------------------------------------
	// unused codes between the inputs and the fieldbus bits read as zero
	always_comb begin
		src_vec = 32'h0000_0000;
		src_vec[SRC_ON] = 1'b1;
		src_vec[SRC_DI_POS +: NUM_DI] = di_sync;
		src_vec[SRC_FBA_POS] = FBA_CW_BIT3;
		src_vec[SRC_EFB_POS] = EFB_CW_BIT3;
	end

	assign mux_sel[0] = in_sel[0];
	assign mux_sel[1] = in_sel[1];
	assign mux_sel[2] = in_sel[2];
	assign mux_sel[3] = run_sel;

	for (genvar k = 0; k < 4; k++) begin : g_mux
		sre_src_mux u_mux (
			.src_vec (src_vec),
			.sel     (mux_sel[k]),
			.bit_out (mux_out[k])
		);
	end

	assign in_cur = mux_out[2:0];
	assign run_en = mux_out[3] == 1'b1;

	// ----------------------------------------
	// edge detection
	// ----------------------------------------
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			in_prev <= 3'h0;
		end else begin
			in_prev <= in_cur;
		end
	end

	assign rise = in_cur & ~in_prev;

	// ----------------------------------------
	// command decoding
	// ----------------------------------------
	// edge mode starts only on a fresh edge, so a held input after a
	// stop does not restart the motor by itself
	assign lvl_a = (trig == TRIG_LEVEL) ? in_cur[0] : rise[0];
	assign lvl_b = (trig == TRIG_LEVEL) ? in_cur[1] : rise[1];

	always_comb begin
		start_req  = 1'b0;
		stop_req   = 1'b0;
		rev_req    = 1'b0;
		dir_follow = 1'b0;
		case (cmd_sel)
			CMD_START: begin
				start_req = lvl_a;
				stop_req  = !in_cur[0];
			end
			CMD_START_DIR: begin
				start_req  = lvl_a;
				stop_req   = !in_cur[0];
				rev_req    = in_cur[1];
				dir_follow = 1'b1;
			end
			CMD_FWD_REV: begin
				stop_req = in_cur[0] == in_cur[1];
				if (lvl_a && !in_cur[1]) begin
					start_req = 1'b1;
				end else if (lvl_b && !in_cur[0]) begin
					start_req = 1'b1;
					rev_req   = 1'b1;
				end
			end
			CMD_P_STOP: begin
				start_req = rise[0] && in_cur[1];
				stop_req  = !in_cur[1];
			end
			CMD_P_STOP_DIR: begin
				start_req  = rise[0] && in_cur[1];
				stop_req   = !in_cur[1];
				rev_req    = in_cur[2];
				dir_follow = 1'b1;
			end
			CMD_P_FR_STOP: begin
				// pulses only; trigger type has no say here
				stop_req = !in_cur[2];
				if (rise[0] && in_cur[2]) begin
					start_req = 1'b1;
				end else if (rise[1] && in_cur[2]) begin
					start_req = 1'b1;
					rev_req   = 1'b1;
				end
			end
			CMD_PANEL: begin
				start_req  = PANEL_START;
				stop_req   = !PANEL_START;
				rev_req    = PANEL_REV;
				dir_follow = 1'b1;
			end
			CMD_FBA: begin
				start_req  = FBA_START;
				stop_req   = !FBA_START;
				rev_req    = FBA_REV;
				dir_follow = 1'b1;
			end
			CMD_EFB: begin
				start_req  = EFB_START;
				stop_req   = !EFB_START;
				rev_req    = EFB_REV;
				dir_follow = 1'b1;
			end
			default: begin
				stop_req = 1'b1;
			end
		endcase
	end

	assign refused = start_req && !run_en && !running;

	// ----------------------------------------
	// run state machine
	// ----------------------------------------
	always_comb begin
		next_state = state;
		next_rev   = REVERSE;
		case (state)
			ST_IDLE: begin
				if (start_req && run_en) begin
					next_state = ST_RUN;
					next_rev   = rev_req;
				end
			end
			ST_RUN: begin
				if (!run_en) begin
					if (stop_mode == STOP_COAST) begin
						next_state = ST_IDLE;
					end else begin
						next_state = ST_RAMP;
					end
				end else if (stop_req) begin
					next_state = ST_RAMP;
				end else if (dir_follow) begin
					next_rev = rev_req;
				end
			end
			ST_RAMP: begin
				// a coast request during a ramp still cuts power at once
				if (!run_en && stop_mode == STOP_COAST) begin
					next_state = ST_IDLE;
				end else if (ZERO_SPEED) begin
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		next_power = next_state != ST_IDLE;
		next_ramp  = next_state == ST_RAMP;
		next_run   = next_state == ST_RUN;
		if (next_state == ST_IDLE) begin
			next_rev = 1'b0;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state          <= ST_IDLE;
			POWER_STAGE_ON <= 1'b0;
			RAMP_STOP      <= 1'b0;
			MOTOR_RUN      <= 1'b0;
			REVERSE        <= 1'b0;
		end else begin
			state          <= next_state;
			POWER_STAGE_ON <= next_power;
			RAMP_STOP      <= next_ramp;
			MOTOR_RUN      <= next_run;
			REVERSE        <= next_rev;
		end
	end
endmodule
`default_nettype wire

// [testbench/sre_top_properties.sv]
// checker for sre_top: relations between the drive outputs
// assumes it is bound onto sre_top, one MCLK domain
`default_nettype none
module sre_top_chk (
	// clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// ramp feedback and drive outputs
	input wire logic ZERO_SPEED,
	input wire logic POWER_STAGE_ON,
	input wire logic RAMP_STOP,
	input wire logic MOTOR_RUN,
	input wire logic REVERSE
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);
	// ----------
	// assertions
	// ----------
	AST_RUN_POWERED:
		assert property (MOTOR_RUN |-> POWER_STAGE_ON && !RAMP_STOP)
		else $error("run without power or with ramp");
	AST_RAMP_POWERED:
		assert property (RAMP_STOP |-> POWER_STAGE_ON && !MOTOR_RUN)
		else $error("ramp without power or with run");
	AST_RAMP_END:
		assert property (RAMP_STOP && ZERO_SPEED
			|=> !POWER_STAGE_ON && !RAMP_STOP)
		else $error("ramp not ended at zero speed");
	AST_RAMP_HOLD:
		assert property (RAMP_STOP && !ZERO_SPEED |=> !MOTOR_RUN)
		else $error("restart during ramp");
	AST_RAMP_EXIT:
		assert property ($fell(RAMP_STOP) |-> !POWER_STAGE_ON)
		else $error("ramp left with power on");
	AST_STOP_KIND:
		assert property ($fell(MOTOR_RUN) |-> RAMP_STOP || !POWER_STAGE_ON)
		else $error("run dropped without a stop");
	AST_START_RUN:
		assert property ($rose(POWER_STAGE_ON) |-> MOTOR_RUN)
		else $error("power on without run");
	AST_REV_IDLE:
		assert property (!POWER_STAGE_ON |-> !REVERSE)
		else $error("reverse while unpowered");
	cover property ($rose(MOTOR_RUN));
	cover property ($rose(RAMP_STOP));
	cover property ($fell(POWER_STAGE_ON) && !$past(RAMP_STOP));
endmodule
bind sre_top sre_top_chk u_chk (
	.MCLK(MCLK),
	.RST_N(RST_N),
	.ZERO_SPEED(ZERO_SPEED),
	.POWER_STAGE_ON(POWER_STAGE_ON),
	.RAMP_STOP(RAMP_STOP),
	.MOTOR_RUN(MOTOR_RUN),
	.REVERSE(REVERSE)
);
`default_nettype wire

// [testbench/sre_ramp_model.sv]
// ramp generator model: reports zero speed after a ramp stop
// assumes decel_cycles is held steady while a ramp runs
`default_nettype none
module sre_ramp_model (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst_n,
	// drive state
	input wire logic       power_on,
	input wire logic       ramp_stop,
	input wire logic [7:0] decel_cycles,
	// feedback
	output logic           zero_speed
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] speed;
	// coasting is taken as instant zero; only the ramp length matters here
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			speed <= 8'h00;
		else if (!power_on)
			speed <= 8'h00;
		else if (!ramp_stop)
			speed <= decel_cycles;
		else if (speed != 8'h00)
			speed <= speed - 8'h01;
	end
	assign zero_speed = (speed == 8'h00);
endmodule
`default_nettype wire

// [testbench/tb_sre_top.sv]
// bench for sre_top: registers over axi4-lite, start, stop, run enable
// assumes the ramp model drives ZERO_SPEED, the bench all else
`default_nettype none
module tb_sre_top
	import sre_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	// ----------
	// signals
	// ----------
	logic        mclk = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  awaddr = 8'h00;
	logic [7:0]  araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic [5:0]  dig_in = 6'h00;
	logic [5:0]  cmd_in = 6'h00;
	logic [7:0]  decel = 8'h00;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	logic        zero_speed, power_on, ramp_stop, motor_run, reverse;
	int          n_errors = 0;
	int          total_checks = 0;
	localparam logic [4:0] LOC[3] = '{CMD_PANEL, CMD_FBA, CMD_EFB};
	always #20 mclk = ~mclk;
	sre_top uut (
		.MCLK(mclk), .RST_N(rst_n),
		.S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata),
		.S_AXI_WSTRB(4'hF), .S_AXI_WVALID(wvalid),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp),
		.S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid),
		.S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid),
		.S_AXI_RREADY(rready), .DIG_IN(dig_in),
		.PANEL_START(cmd_in[0]), .PANEL_REV(cmd_in[1]),
		.FBA_START(cmd_in[2]), .FBA_REV(cmd_in[3]),
		.EFB_START(cmd_in[4]), .EFB_REV(cmd_in[5]),
		.FBA_CW_BIT3(1'b0), .EFB_CW_BIT3(1'b0),
		.ZERO_SPEED(zero_speed), .POWER_STAGE_ON(power_on),
		.RAMP_STOP(ramp_stop), .MOTOR_RUN(motor_run), .REVERSE(reverse)
	);
	sre_ramp_model u_ramp (
		.clk(mclk), .rst_n(rst_n), .power_on(power_on),
		.ramp_stop(ramp_stop), .decel_cycles(decel),
		.zero_speed(zero_speed)
	);
	// ----------
	// tasks
	// ----------
	task automatic chk(input string n, input logic [31:0] s, e);
		total_checks++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic summarize();
		$display("checks %0d errors %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] er);
		bit aw, w;
		aw = 1;
		w = 1;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (aw || w) begin
			@(posedge mclk);
			if (aw && awready === 1'b1) begin
				aw = 0;
				awvalid <= 1'b0;
			end
			if (w && wready === 1'b1) begin
				w = 0;
				wvalid <= 1'b0;
			end
		end
		do @(posedge mclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, bresp}, {30'h0, er});
	endtask
	task automatic axr(input logic [7:0] a, input logic [31:0] m, e,
		input logic [1:0] er);
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge mclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge mclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		chk("rresp", {30'h0, rresp}, {30'h0, er});
		chk("rdata", rdata & m, e);
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge mclk);
	endtask
	// outputs in the order power, ramp, run, reverse
	task automatic outs(input logic [3:0] e);
		#1;
		chk("outputs", {28'h0, power_on, ramp_stop, motor_run, reverse},
			{28'h0, e});
	endtask
	// bounded: the slowest ramp used here is 20 cycles
	task automatic wait_off();
		for (int i = 0; i < 100 && power_on !== 1'b0; i++) begin
			@(posedge mclk);
			#1;
		end
		chk("stop wait", {31'h0, power_on}, 32'h0);
	endtask
	// ----------
	// tests
	// ----------
	initial begin
		cyc(5);
		rst_n <= 1'b1;
		axr(OFF_IN_B, 32'h1F, 32'h0, RESP_OKAY);
		axr(OFF_IN_C, 32'h1F, 32'h0, RESP_OKAY);
		axr(OFF_STOP, 32'h1, 32'h0, RESP_OKAY);
		axr(OFF_RUN_SEL, 32'h1F, 32'h1, RESP_OKAY);
		axr(8'h20, 32'hFFFFFFFF, 32'h0, RESP_SLVERR);
		axw(OFF_STATUS, 32'h0, RESP_SLVERR);
		axw(OFF_RUN_SEL, 32'h2, RESP_OKAY);
		axw(OFF_IN_A, 32'h1, RESP_OKAY);
		axw(OFF_CMD_SEL, 32'h1, RESP_OKAY);
		cyc(4);
		outs(4'h0);
		axr(OFF_STATUS, 32'h18, 32'h10, RESP_OKAY);
		@(posedge mclk) dig_in <= 6'h01;
		cyc(4);
		outs(4'hA);
		axw(OFF_RUN_SEL, 32'h3, RESP_SLVERR);
		axr(OFF_RUN_SEL, 32'h1F, 32'h2, RESP_OKAY);
		// two sync edges plus one decision edge, no slack for coast
		@(posedge mclk) dig_in <= 6'h00;
		cyc(3);
		outs(4'h0);
		axw(OFF_RUN_SEL, 32'h3, RESP_OKAY);
		axw(OFF_STOP, 32'h1, RESP_OKAY);
		@(posedge mclk) decel <= 8'h14;
		@(posedge mclk) dig_in <= 6'h02;
		cyc(4);
		outs(4'hA);
		@(posedge mclk) dig_in <= 6'h00;
		cyc(3);
		outs(4'hC);
		cyc(10);
		outs(4'hC);
		wait_off();
		axw(OFF_RUN_SEL, 32'h1, RESP_OKAY);
		@(posedge mclk) decel <= 8'h00;
		for (int i = 0; i < 3; i++) begin
			axw(OFF_CMD_SEL, {27'h0, LOC[i]}, RESP_OKAY);
			@(posedge mclk) cmd_in <= 6'h15 & ~(6'h03 << (2 * i));
			cyc(4);
			outs(4'h0);
			@(posedge mclk) cmd_in <= 6'h03 << (2 * i);
			cyc(3);
			outs(4'hB);
			@(posedge mclk) cmd_in <= 6'h00;
			wait_off();
		end
		axw(OFF_IN_A, 32'h2, RESP_OKAY);
		axw(OFF_IN_B, 32'h1, RESP_OKAY);
		@(posedge mclk) dig_in <= 6'h01;
		cyc(3);
		// level trigger still set: a held input must not start pulse mode
		axw(OFF_CMD_SEL, {27'h0, CMD_P_STOP}, RESP_OKAY);
		cyc(4);
		outs(4'h0);
		@(posedge mclk) dig_in <= 6'h00;
		cyc(3);
		@(posedge mclk) dig_in <= 6'h01;
		cyc(4);
		outs(4'hA);
		// pulse fwd/rev/stop mode: a held first input under level trigger
		// must not start it; only a fresh pulse on the second input does
		axw(OFF_IN_C, 32'h1, RESP_OKAY);
		axw(OFF_IN_B, 32'h3, RESP_OKAY);
		axw(OFF_CMD_SEL, {27'h0, CMD_P_FR_STOP}, RESP_OKAY);
		cyc(4);
		outs(4'h0);
		@(posedge mclk) dig_in <= 6'h03;
		cyc(4);
		outs(4'hB);
		axw(OFF_IN_C, 32'h0, RESP_OKAY);
		wait_off();
		summarize();
	end
	// the tests need under 300 cycles; allow ample headroom
	initial begin
		cyc(20000);
		n_errors++;
		summarize();
	end
endmodule
`default_nettype wire
